// ---- pkg/hpm_pkg.sv ----
package hpm_pkg;

  // Channel indices
  localparam int HPM_CHANNELS = 2;
  localparam int HPM_CH_FIRST = 0;
  localparam int HPM_CH_SECOND = 1;

  // Status register field positions
  localparam int HPM_ST_CMD = 3;
  localparam int HPM_ST_IBF = 1;
  localparam int HPM_ST_OBF = 0;
  localparam logic [7:0] HPM_ST_RESET = 8'h00;
  localparam logic [7:0] HPM_ST_USER_MASK = 8'hf4;

  // System control and interrupt enable fields
  localparam int HPM_SYS_HIE = 1;
  localparam int HPM_IE_FIRST = 1;
  localparam int HPM_IE_SECOND = 2;
  localparam logic [7:0] HPM_IE_FILL = 8'hf8;
  localparam logic [7:0] HPM_ZERO = 8'h00;

  // Slave register selects
  typedef enum logic [2:0] {
    HPM_SEL_IN,
    HPM_SEL_OUT,
    HPM_SEL_STAT,
    HPM_SEL_SYS,
    HPM_SEL_IE
  } hpm_sel_t;

  // Host pin group, strobes and selects active low
  typedef struct packed {
    logic       sel1_n;
    logic       sel2_n;
    logic       rd_n;
    logic       wr_n;
    logic       a0;
    logic [7:0] data;
  } hpm_host_t;

  localparam hpm_host_t HPM_HOST_IDLE = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 8'h00};

  // Slave internal access, rd and wr are level pulses
  typedef struct packed {
    logic       rd;
    logic       wr;
    logic       ch;
    hpm_sel_t   sel;
    logic [7:0] wdata;
  } hpm_slave_t;

  localparam hpm_slave_t HPM_SLAVE_IDLE = '{1'b0, 1'b0, 1'b0, HPM_SEL_IN, 8'h00};

  typedef struct packed {
    hpm_host_t       s1;
    hpm_host_t       s2;
    hpm_host_t       s3;
    hpm_slave_t      sreq;
    logic [1:0][7:0] in_data;
    logic [1:0][7:0] out_data;
    logic [1:0][7:0] status;
    logic            host_port_enable;
    logic [1:0]      ie;
    logic [7:0]      rdata;
    logic [7:0]      hdata;
    logic            hoe_n;
  } hpm_state_t;

endpackage

// ---- rtl/hpm_top.sv ----
`timescale 1ns/100ps

module hpm_top (
  input  wire logic                clock_i,            // 200 MHz chip clock
  input  wire logic                rstn_i,             // Async reset, active low
  input  wire logic                standby_i,          // Standby mode level
  input  wire hpm_pkg::hpm_host_t  host_i,             // Host pins, asynchronous
  output logic [7:0]               host_data_o,        // Host data bus out
  output logic                     host_data_oe_n_o,   // Low while driving
  output logic                     host_port_active_o, // Pins owned by port
  input  wire hpm_pkg::hpm_slave_t slave_i,            // Slave register access
  output logic [7:0]               slave_rdata_o,      // Slave read data
  output logic [1:0]               irq_in_full_o       // Input-full requests
);

  localparam hpm_pkg::hpm_state_t RESET_STATE = '{
    s1:       hpm_pkg::HPM_HOST_IDLE,
    s2:       hpm_pkg::HPM_HOST_IDLE,
    s3:       hpm_pkg::HPM_HOST_IDLE,
    sreq:     hpm_pkg::HPM_SLAVE_IDLE,
    in_data:  '0,
    out_data: '0,
    status:   {hpm_pkg::HPM_ST_RESET, hpm_pkg::HPM_ST_RESET},
    host_port_enable:      1'b0,
    ie:       2'b00,
    rdata:    hpm_pkg::HPM_ZERO,
    hdata:    hpm_pkg::HPM_ZERO,
    hoe_n:    1'b1
  };

  hpm_pkg::hpm_state_t st;
  hpm_pkg::hpm_state_t next_st;

  logic       w_rise;   // Host write strobe just released
  logic       r_rise;   // Host read strobe just released
  logic       s_rd_fall; // Slave read pulse ends
  logic       s_wr_fall; // Slave write pulse ends
  logic [1:0] ev_sel;   // Channel selected at the strobe release
  logic [1:0] rd_sel;   // Channel selected for a live host read
  logic       host_rd;  // Live host read on a valid channel

  // Host events come from the second and third sync stages only
  assign w_rise = st.host_port_enable & st.s2.wr_n & ~st.s3.wr_n & st.s3.rd_n;
  assign r_rise = st.host_port_enable & st.s2.rd_n & ~st.s3.rd_n & st.s3.wr_n;
  assign ev_sel[hpm_pkg::HPM_CH_FIRST] = ~st.s3.sel1_n & st.s3.sel2_n;
  assign ev_sel[hpm_pkg::HPM_CH_SECOND] = ~st.s3.sel2_n & st.s3.sel1_n;
  assign rd_sel[hpm_pkg::HPM_CH_FIRST] = ~st.s2.sel1_n & st.s2.sel2_n;
  assign rd_sel[hpm_pkg::HPM_CH_SECOND] = ~st.s2.sel2_n & st.s2.sel1_n;
  // Both strobes low is prohibited, so it counts as no access
  assign host_rd = st.host_port_enable & ~st.s2.rd_n & st.s2.wr_n & (|rd_sel);

  // Slave pulses act on their trailing edge
  assign s_rd_fall = st.sreq.rd & ~slave_i.rd;
  assign s_wr_fall = st.sreq.wr & ~slave_i.wr;

  // Next state; flag clears come before sets so a set in the same cycle wins, and standby comes last so its clear wins
  always_comb begin
    next_st = st;
    next_st.s1 = host_i;
    next_st.s2 = st.s1;
    next_st.s3 = st.s2;
    next_st.sreq = slave_i;
    for (int c = 0; c < hpm_pkg::HPM_CHANNELS; c++) begin
      if (s_rd_fall && st.sreq.ch == 1'(c) && st.sreq.sel == hpm_pkg::HPM_SEL_IN) begin
        next_st.status[c][hpm_pkg::HPM_ST_IBF] = 1'b0;
      end
      if (r_rise && ev_sel[c] && !st.s3.a0) begin
        next_st.status[c][hpm_pkg::HPM_ST_OBF] = 1'b0;
      end
      if (s_wr_fall && st.sreq.ch == 1'(c) && st.sreq.sel == hpm_pkg::HPM_SEL_OUT) begin
        next_st.out_data[c] = st.sreq.wdata;
        next_st.status[c][hpm_pkg::HPM_ST_OBF] = 1'b1;
      end
      // Only user bits take slave writes; flags stay hardware owned
      // Built on next_st so a host read clear in this same cycle is not undone
      if (s_wr_fall && st.sreq.ch == 1'(c) && st.sreq.sel == hpm_pkg::HPM_SEL_STAT) begin
        next_st.status[c] = (next_st.status[c] & ~hpm_pkg::HPM_ST_USER_MASK)
                          | (st.sreq.wdata & hpm_pkg::HPM_ST_USER_MASK);
      end
      if (w_rise && ev_sel[c]) begin
        next_st.in_data[c] = st.s3.data;
        next_st.status[c][hpm_pkg::HPM_ST_CMD] = st.s3.a0;
        next_st.status[c][hpm_pkg::HPM_ST_IBF] = 1'b1;
      end
      if (standby_i) begin
        next_st.status[c] = hpm_pkg::HPM_ST_RESET;
      end
    end
    // Control registers
    if (s_wr_fall && st.sreq.sel == hpm_pkg::HPM_SEL_SYS) begin
      next_st.host_port_enable = st.sreq.wdata[hpm_pkg::HPM_SYS_HIE];
    end
    if (s_wr_fall && st.sreq.sel == hpm_pkg::HPM_SEL_IE) begin
      next_st.ie[hpm_pkg::HPM_CH_FIRST] = st.sreq.wdata[hpm_pkg::HPM_IE_FIRST];
      next_st.ie[hpm_pkg::HPM_CH_SECOND] = st.sreq.wdata[hpm_pkg::HPM_IE_SECOND];
    end
    if (standby_i) begin
      next_st.ie = 2'b00;
    end
    // Host read path: data or status by address bit 0
    next_st.hoe_n = ~host_rd;
    if (st.s2.a0) begin
      next_st.hdata = st.status[rd_sel[hpm_pkg::HPM_CH_SECOND]];
    end else begin
      next_st.hdata = st.out_data[rd_sel[hpm_pkg::HPM_CH_SECOND]];
    end
    // Slave read data, answered one cycle after the pulse starts
    if (slave_i.rd) begin
      if (slave_i.sel == hpm_pkg::HPM_SEL_IN) begin
        next_st.rdata = st.in_data[slave_i.ch];
      end else if (slave_i.sel == hpm_pkg::HPM_SEL_OUT) begin
        next_st.rdata = st.out_data[slave_i.ch];
      end else if (slave_i.sel == hpm_pkg::HPM_SEL_STAT) begin
        next_st.rdata = st.status[slave_i.ch];
      end else if (slave_i.sel == hpm_pkg::HPM_SEL_SYS) begin
        next_st.rdata = hpm_pkg::HPM_ZERO;
        next_st.rdata[hpm_pkg::HPM_SYS_HIE] = st.host_port_enable;
      end else begin
        next_st.rdata = hpm_pkg::HPM_IE_FILL;
        next_st.rdata[hpm_pkg::HPM_IE_FIRST] = st.ie[hpm_pkg::HPM_CH_FIRST];
        next_st.rdata[hpm_pkg::HPM_IE_SECOND] = st.ie[hpm_pkg::HPM_CH_SECOND];
      end
    end
  end

  // State register; input data is reset only for tidiness, software may not rely on it
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      st <= RESET_STATE;
    end else begin
      st <= next_st;
    end
  end

  // Outputs
  assign host_data_o = st.hdata;
  assign host_data_oe_n_o = st.hoe_n;
  assign host_port_active_o = st.host_port_enable;
  assign slave_rdata_o = st.rdata;
  // Level requests follow the flag, so a slow handler never misses one
  assign irq_in_full_o[hpm_pkg::HPM_CH_FIRST] = st.ie[hpm_pkg::HPM_CH_FIRST]
                                              & st.status[hpm_pkg::HPM_CH_FIRST][hpm_pkg::HPM_ST_IBF];
  assign irq_in_full_o[hpm_pkg::HPM_CH_SECOND] = st.ie[hpm_pkg::HPM_CH_SECOND]
                                               & st.status[hpm_pkg::HPM_CH_SECOND][hpm_pkg::HPM_ST_IBF];

  // Checks
  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (!rstn_i);

  sequence seq_wr2;
    w_rise && ev_sel[hpm_pkg::HPM_CH_SECOND] && !standby_i;
  endsequence

  sequence seq_rd2_data;
    r_rise && ev_sel[hpm_pkg::HPM_CH_SECOND] && !st.s3.a0;
  endsequence

  sequence seq_srd_in2;
    s_rd_fall && st.sreq.ch && st.sreq.sel == hpm_pkg::HPM_SEL_IN;
  endsequence

  sequence seq_swr_out2;
    s_wr_fall && st.sreq.ch && st.sreq.sel == hpm_pkg::HPM_SEL_OUT;
  endsequence

  chk_in_capture: assert property (
    seq_wr2 |=> st.in_data[1] == $past(st.s3.data))
    else $error("input data not captured on write strobe release");

  chk_cmd_flag: assert property (
    seq_wr2 |=> st.status[1][hpm_pkg::HPM_ST_CMD] == $past(st.s3.a0))
    else $error("command flag does not follow address bit 0");

  chk_ibf_set: assert property (
    seq_wr2 |=> st.status[1][hpm_pkg::HPM_ST_IBF])
    else $error("input-full not set by host write");

  chk_ibf_clear: assert property (
    seq_srd_in2 and (!w_rise && !standby_i) |=> !st.status[1][hpm_pkg::HPM_ST_IBF])
    else $error("input-full not cleared by slave read");

  chk_obf_set: assert property (
    seq_swr_out2 and !standby_i |=> st.status[1][hpm_pkg::HPM_ST_OBF]
      && st.out_data[1] == $past(st.sreq.wdata))
    else $error("output-full or output data wrong after slave write");

  chk_obf_clear: assert property (
    seq_rd2_data and !(s_wr_fall && st.sreq.sel == hpm_pkg::HPM_SEL_OUT)
      |=> !st.status[1][hpm_pkg::HPM_ST_OBF])
    else $error("output-full not cleared by host read");

  chk_status_zero: assert property (
    standby_i |=> st.status[1] == hpm_pkg::HPM_ST_RESET)
    else $error("status not cleared in standby");

  chk_user_bits: assert property (
    s_wr_fall && st.sreq.ch && st.sreq.sel == hpm_pkg::HPM_SEL_STAT && !standby_i
      |=> (st.status[1] & hpm_pkg::HPM_ST_USER_MASK)
        == ($past(st.sreq.wdata) & hpm_pkg::HPM_ST_USER_MASK))
    else $error("user status bits not stored");

  chk_flags_held: assert property (
    !w_rise && !r_rise && !s_rd_fall && !s_wr_fall && !standby_i
      |=> $stable(st.status[1][hpm_pkg::HPM_ST_CMD]) && $stable(st.status[1][hpm_pkg::HPM_ST_OBF]))
    else $error("read-only status bit changed without cause");

  chk_irq_gate: assert property (
    irq_in_full_o[1] == (st.ie[1] && st.status[1][hpm_pkg::HPM_ST_IBF]))
    else $error("second input-full request wrong");

  chk_read_drive: assert property (
    st.host_port_enable && !st.s2.rd_n && st.s2.wr_n && rd_sel[1] && !st.s2.a0 && !w_rise ##0 $stable(st.out_data)
      |=> !host_data_oe_n_o && host_data_o == $past(st.out_data[1]))
    else $error("output data not driven on host read");

  chk_port_off: assert property (
    !st.host_port_enable |=> host_data_oe_n_o && $stable(st.in_data))
    else $error("host port active while disabled");

  // First channel events, the same shapes as the second channel
  sequence seq_wr1;
    w_rise && ev_sel[hpm_pkg::HPM_CH_FIRST] && !standby_i;
  endsequence

  sequence seq_rd1_data;
    r_rise && ev_sel[hpm_pkg::HPM_CH_FIRST] && !st.s3.a0;
  endsequence

  sequence seq_srd_in1;
    s_rd_fall && !st.sreq.ch && st.sreq.sel == hpm_pkg::HPM_SEL_IN;
  endsequence

  sequence seq_swr_out1;
    s_wr_fall && !st.sreq.ch && st.sreq.sel == hpm_pkg::HPM_SEL_OUT;
  endsequence

  chk_in1_capture: assert property (
    seq_wr1 |=> st.in_data[0] == $past(st.s3.data) && st.status[0][hpm_pkg::HPM_ST_IBF]
      && st.status[0][hpm_pkg::HPM_ST_CMD] == $past(st.s3.a0))
    else $error("first channel host write not taken");

  chk_ibf1_clear: assert property (
    seq_srd_in1 and (!w_rise && !standby_i) |=> !st.status[0][hpm_pkg::HPM_ST_IBF])
    else $error("first input-full not cleared by slave read");

  chk_obf1_set: assert property (
    seq_swr_out1 and !standby_i |=> st.status[0][hpm_pkg::HPM_ST_OBF]
      && st.out_data[0] == $past(st.sreq.wdata))
    else $error("first output data or its flag wrong after slave write");

  // A slave write of the output register in the same cycle wins over the clear
  chk_obf1_clear: assert property (
    seq_rd1_data and !(s_wr_fall && st.sreq.sel == hpm_pkg::HPM_SEL_OUT)
      |=> !st.status[0][hpm_pkg::HPM_ST_OBF])
    else $error("first output-full not cleared by host read");

  // Host read data per channel and address bit 0
  chk_data1_drive: assert property (
    host_rd && rd_sel[hpm_pkg::HPM_CH_FIRST] && !st.s2.a0
      |=> !host_data_oe_n_o && host_data_o == $past(st.out_data[0]))
    else $error("first output data not driven on host read");

  chk_stat1_drive: assert property (
    host_rd && rd_sel[hpm_pkg::HPM_CH_FIRST] && st.s2.a0
      |=> !host_data_oe_n_o && host_data_o == $past(st.status[0]))
    else $error("first status not driven on host read");

  chk_stat2_drive: assert property (
    host_rd && rd_sel[hpm_pkg::HPM_CH_SECOND] && st.s2.a0
      |=> !host_data_oe_n_o && host_data_o == $past(st.status[1]))
    else $error("second status not driven on host read");

  // Prohibited strobe and select combinations leave the port idle
  chk_both_strobes: assert property (
    !st.s2.rd_n && !st.s2.wr_n |=> host_data_oe_n_o)
    else $error("bus driven with both strobes low");

  chk_both_no_write: assert property (
    !st.s3.rd_n && !st.s3.wr_n |=> $stable(st.in_data))
    else $error("input data written with both strobes low");

  chk_no_select_rd: assert property (
    st.s2.sel1_n == st.s2.sel2_n |=> host_data_oe_n_o)
    else $error("bus driven without a single channel select");

  chk_no_select_wr: assert property (
    st.s3.sel1_n == st.s3.sel2_n |=> $stable(st.in_data))
    else $error("input data written without a single channel select");

  // Standby clears the first status and the second interrupt enable too
  chk_status1_zero: assert property (
    standby_i |=> st.status[0] == hpm_pkg::HPM_ST_RESET)
    else $error("first status not cleared in standby");

  chk_irq_standby: assert property (
    standby_i |=> !st.ie[hpm_pkg::HPM_CH_SECOND] && !irq_in_full_o[hpm_pkg::HPM_CH_SECOND])
    else $error("second input-full request survives standby");

  // Slave reads answer one cycle later from the addressed register
  chk_slave_in2: assert property (
    slave_i.rd && slave_i.ch && slave_i.sel == hpm_pkg::HPM_SEL_IN
      |=> slave_rdata_o == $past(st.in_data[1]))
    else $error("slave read of second input data wrong");

  chk_slave_stat2: assert property (
    slave_i.rd && slave_i.ch && slave_i.sel == hpm_pkg::HPM_SEL_STAT
      |=> slave_rdata_o == $past(st.status[1]))
    else $error("slave read of second status wrong");

  chk_enable_write: assert property (
    s_wr_fall && st.sreq.sel == hpm_pkg::HPM_SEL_SYS
      |=> st.host_port_enable == $past(st.sreq.wdata[hpm_pkg::HPM_SYS_HIE]))
    else $error("interface enable not taken from slave write");

  // Registers change only for their own events
  chk_user_held: assert property (
    !(s_wr_fall && st.sreq.sel == hpm_pkg::HPM_SEL_STAT) && !standby_i
      |=> $stable(st.status[1] & hpm_pkg::HPM_ST_USER_MASK))
    else $error("user status bits changed without a slave write");

  chk_ibf_held: assert property (
    !w_rise && !s_rd_fall && !standby_i |=> $stable(st.status[1][hpm_pkg::HPM_ST_IBF]))
    else $error("input-full changed without cause");

  chk_out_held: assert property (
    !s_wr_fall |=> $stable(st.out_data[1]))
    else $error("second output data changed without slave write");

  chk_in_held: assert property (
    !w_rise |=> $stable(st.in_data))
    else $error("input data changed without host write");

endmodule

// ---- tb/hpm_host_model.sv ----
`timescale 1ns/100ps

module hpm_host_model (
  input  wire logic         clock_i,   // Chip clock, paces the host
  input  wire logic [7:0]   data_i,    // Device read data
  input  wire logic         oe_n_i,    // Device drive enable, active low
  output hpm_pkg::hpm_host_t host_o    // Host pins
);
  initial host_o = hpm_pkg::HPM_HOST_IDLE;

  task automatic wait_n(input int n);
    repeat (n) @(posedge clock_i);
  endtask

  // Write: strobe low 3 cycles, pins held past the rising edge so the sync sees them
  task automatic write(input logic ch2, input logic a0, input logic [7:0] d);
    @(posedge clock_i);
    host_o <= '{ch2, ~ch2, 1'b1, 1'b0, a0, d};
    wait_n(3);
    host_o.wr_n <= 1'b1;
    wait_n(3);
    // Released bus shows the inverse, never the stale byte
    host_o <= '{1'b1, 1'b1, 1'b1, 1'b1, ~a0, ~d};
    wait_n(2);
  endtask

  // Read: data is taken well after the 3-edge answer latency
  task automatic read(input logic ch2, input logic a0, output logic [7:0] d, output logic oe_n);
    @(posedge clock_i);
    host_o <= '{ch2, ~ch2, 1'b0, 1'b1, a0, ~host_o.data};
    wait_n(5);
    // Sample off the edge, where the registered drive has settled
    #1;
    d = data_i;
    oe_n = oe_n_i;
    host_o.rd_n <= 1'b1;
    wait_n(4);
    host_o <= '{1'b1, 1'b1, 1'b1, 1'b1, ~a0, ~host_o.data};
    wait_n(2);
  endtask
endmodule

// ---- tb/tb_hpm_top.sv ----
`timescale 1ns/100ps

module tb_hpm_top;
  logic                clock_i = 1'b0;
  logic                rstn_i = 1'b0;
  logic                standby_i = 1'b0;
  hpm_pkg::hpm_host_t  host_w;
  hpm_pkg::hpm_slave_t slave_i = hpm_pkg::HPM_SLAVE_IDLE;
  logic [7:0]          host_data_o;
  logic                host_data_oe_n_o;
  logic                host_port_active_o;
  logic [7:0]          slave_rdata_o;
  logic [1:0]          irq_in_full_o;
  logic [7:0]          d;
  logic                oe_n;
  int                  n_errors = 0;
  int                  comparisons = 0;
  localparam logic [7:0] USR = hpm_pkg::HPM_ST_USER_MASK;

  // 200 MHz clock
  always #2.5 clock_i = ~clock_i;

  hpm_top dut (.clock_i(clock_i), .rstn_i(rstn_i), .standby_i(standby_i), .host_i(host_w),
    .host_data_o(host_data_o), .host_data_oe_n_o(host_data_oe_n_o),
    .host_port_active_o(host_port_active_o), .slave_i(slave_i), .slave_rdata_o(slave_rdata_o),
    .irq_in_full_o(irq_in_full_o));

  hpm_host_model host (.clock_i(clock_i), .data_i(host_data_o), .oe_n_i(host_data_oe_n_o), .host_o(host_w));

  task automatic check8(input logic [7:0] got, input logic [7:0] exp, input string what);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  // Slave pulses leave at least two low cycles before the next access
  task automatic slave_wr(input logic ch, input hpm_pkg::hpm_sel_t sel, input logic [7:0] v);
    @(posedge clock_i);
    slave_i <= '{1'b0, 1'b1, ch, sel, v};
    @(posedge clock_i);
    slave_i.wr <= 1'b0;
    repeat (2) @(posedge clock_i);
  endtask

  task automatic slave_chk(input logic ch, input hpm_pkg::hpm_sel_t sel, input logic [7:0] exp);
    @(posedge clock_i);
    slave_i <= '{1'b1, 1'b0, ch, sel, 8'h00};
    @(posedge clock_i);
    slave_i.rd <= 1'b0;
    @(posedge clock_i);
    #1 check8(slave_rdata_o, exp, "slave read");
  endtask

  task automatic host_chk(input logic ch2, input logic a0, input logic [7:0] exp);
    logic oe;
    host.read(ch2, a0, d, oe);
    check8(d, exp, "host read");
    check8({7'h00, oe}, 8'h00, "host drive enable");
  endtask

  task automatic final_report();
    $display("comparisons %0d mismatches %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // Watchdog well past the expected run of a couple of hundred cycles
  initial begin
    #100us;
    n_errors++;
    final_report();
  end

  initial begin
    repeat (16) @(posedge clock_i);
    rstn_i <= 1'b1;
    // Port disabled: host writes are ignored and reads find no drive
    host.write(1'b1, 1'b1, 8'h5a);
    slave_chk(1'b1, hpm_pkg::HPM_SEL_STAT, 8'h00);
    host.read(1'b1, 1'b1, d, oe_n);
    check8({7'h00, oe_n}, 8'h01, "drive off while disabled");
    check8({7'h00, host_port_active_o}, 8'h00, "port idle");
    slave_wr(1'b0, hpm_pkg::HPM_SEL_SYS, 8'h02);
    check8({7'h00, host_port_active_o}, 8'h01, "port active");
    $display("test enable done");
    // User bits writable, flags not
    slave_wr(1'b1, hpm_pkg::HPM_SEL_STAT, 8'hff);
    slave_chk(1'b1, hpm_pkg::HPM_SEL_STAT, USR);
    host_chk(1'b1, 1'b1, USR);
    $display("test status done");
    // Command write, interrupt gated by its enable
    host.write(1'b1, 1'b1, 8'h5a);
    slave_chk(1'b1, hpm_pkg::HPM_SEL_STAT, USR | 8'h0a);
    check8({6'h00, irq_in_full_o}, 8'h00, "irq masked");
    slave_wr(1'b0, hpm_pkg::HPM_SEL_IE, 8'h04);
    check8({6'h00, irq_in_full_o}, 8'h02, "irq raised");
    slave_chk(1'b1, hpm_pkg::HPM_SEL_IN, 8'h5a);
    slave_chk(1'b1, hpm_pkg::HPM_SEL_STAT, USR | 8'h08);
    check8({6'h00, irq_in_full_o}, 8'h00, "irq cleared");
    host.write(1'b1, 1'b0, 8'ha5);
    slave_chk(1'b1, hpm_pkg::HPM_SEL_STAT, USR | 8'h02);
    $display("test input done");
    // Output path and its flag
    slave_wr(1'b1, hpm_pkg::HPM_SEL_OUT, 8'h3c);
    slave_chk(1'b1, hpm_pkg::HPM_SEL_STAT, USR | 8'h03);
    host_chk(1'b1, 1'b0, 8'h3c);
    host_chk(1'b1, 1'b1, USR | 8'h02);
    $display("test output done");
    // First channel decode
    host.write(1'b0, 1'b1, 8'h11);
    slave_chk(1'b0, hpm_pkg::HPM_SEL_IN, 8'h11);
    slave_wr(1'b0, hpm_pkg::HPM_SEL_OUT, 8'h22);
    host_chk(1'b0, 1'b0, 8'h22);
    host_chk(1'b0, 1'b1, 8'h08);
    slave_chk(1'b1, hpm_pkg::HPM_SEL_IN, 8'ha5);
    $display("test first channel done");
    // Standby clears status
    @(posedge clock_i);
    standby_i <= 1'b1;
    repeat (2) @(posedge clock_i);
    standby_i <= 1'b0;
    slave_chk(1'b1, hpm_pkg::HPM_SEL_STAT, 8'h00);
    $display("test standby done");
    final_report();
  end
endmodule
